//--- src/drc_map.svh
// register map, field positions, reset values and timing counts
//=============================================================================
// What this block does
// RL1: capture starts on manual trigger or any selected binary trigger input.
// RL2: never more than 100 stored recordings.
// RL3: enable setting 0 means on, 1 means off; reset value 0.
// RL4: status codes 0 ready,1 triggered,2 capture+store,3 store,4 full,5 bad.
// RL5: writing N to clear-record deletes Nth stored recording, 1 is first.
// RL6: manual trigger code 1 starts capture; field returns to 0 itself.
// RL7: one-shot commands clear all, newest only, or oldest only.
// RL8: read-only count of recordings that fit, limited to 100.
// RL9: read-only longest single recording length in milliseconds.
// RL10: read-only largest allowed pre-trigger time.
// RL11: read-only count of recordings currently stored.
// RL12: host selects trigger inputs, each enabled individually.
// RL13: recording length 0.1 s to 1800 s, 0.01 s steps, reset 1 s.
// RL14: when full, mode 0 overwrites oldest, mode 1 rejects; reset mode 0.
// RL15: sample rate codes 0..3 select 64,32,16,8 per cycle; reset 64.
// RL16: digital channels sampled every 5 ms, fixed.
// RL17: pre-trigger 0.2 s to 30 s, 0.1 s steps, reset 0.2 s.
// RL18: each of twenty analog slots maps to one channel or unused.
// RL19: each digital slot maps to one binary signal.
// RL20: at most six recordings wait in transfer area; pushes pause when full.
// RL21: a transferred recording is no longer offered by normal read-out.
// RL22: not ready unless max length nonzero, needing a selected trigger.
// RL23: while armed, newest samples kept circularly over the pre-trigger time.
// RL24: triggers ignored while disabled or already capturing.
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH

//=============================================================================
// register offsets
`define DRC_OFS_CTRL     12'h000
`define DRC_OFS_STATUS   12'h004
`define DRC_OFS_CLRIDX   12'h008
`define DRC_OFS_CMD      12'h00c
`define DRC_OFS_RECLEN   12'h010
`define DRC_OFS_PRETRIG  12'h014
`define DRC_OFS_TRIGSEL  12'h018
`define DRC_OFS_MAXNUM   12'h01c
`define DRC_OFS_MAXLEN   12'h020
`define DRC_OFS_MAXPRE   12'h024
`define DRC_OFS_COUNT    12'h028
`define DRC_OFS_XFER     12'h02c
`define DRC_OFS_DIGSEL   12'h030
`define DRC_OFS_ANASEL   12'h040

//=============================================================================
// field positions
`define DRC_CTRL_DIS     0
`define DRC_CTRL_MODE    1
`define DRC_CTRL_RATE    2
`define DRC_CTRL_AUTO    4
`define DRC_CMD_TRIG     0
`define DRC_CMD_CLRALL   1
`define DRC_CMD_CLRNEW   2
`define DRC_CMD_CLROLD   3

//=============================================================================
// reset values and limits
`define DRC_MAX_REC      7'h64
`define DRC_RECLEN_RST   18'h00064
`define DRC_RECLEN_MIN   18'h0000a
`define DRC_RECLEN_MAX   18'h2bf20
`define DRC_PRE_RST      9'h002
`define DRC_PRE_MIN      9'h002
`define DRC_PRE_MAX      9'h12c
`define DRC_XFER_SLOTS   3'h6
`define DRC_NUM_ANA      20
`define DRC_NUM_DIG      96

//=============================================================================
// timing
`define DRC_CLK_HZ       50000000
`define DRC_DIG_MS       5
`define DRC_DIG_CYC      ((`DRC_CLK_HZ / 1000) * `DRC_DIG_MS)
`define DRC_MS_CYC       (`DRC_CLK_HZ / 1000)
`define DRC_SAMPLE_BYTES 16076647

`endif

//--- src/drc_pkg.sv
// types shared by the recorder control
package drc_pkg;
  typedef enum logic [2:0] {
    DRC_READY   = 3'h0,
    DRC_TRIGD   = 3'h1,
    DRC_CAPSTOR = 3'h2,
    DRC_STORING = 3'h3,
    DRC_FULL    = 3'h4,
    DRC_BADCFG  = 3'h5
  } drc_state_t;
endpackage

//--- src/drc_recorder_ctrl.sv
// disturbance recorder control with AXI4-Lite settings slave
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "drc_map.svh"
module drc_recorder_ctrl
  import drc_pkg::*;
#(
  parameter int TRIG_W  = 32,
  parameter int ANA_CH  = 32,
  parameter int SAMP_W  = 16,
  parameter int DIG_CYC = `DRC_DIG_CYC,
  parameter int MS_CYC  = `DRC_MS_CYC,
  parameter int STORE_CYC = 8
) (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [11:0]                 s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [11:0]                 s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [TRIG_W-1:0]           binSignals,
  input  wire logic [ANA_CH*SAMP_W-1:0]    anaSamples,
  input  wire logic                        anaStrobe,
  output logic [SAMP_W-1:0]                anaSlotData [`DRC_NUM_ANA],
  output logic                             anaSlotValid,
  output logic [`DRC_NUM_DIG-1:0]          digSlotData,
  output logic                             digSlotValid,
  output logic                             preWindow,
  output logic                             recPush,
  input  wire logic                        xferTaken
);
  //===========================================================================
  // pin synchronisers
  logic [TRIG_W-1:0] binMeta_r, binSync_r, binPrev_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      binMeta_r <= '0;
      binSync_r <= '0;
      binPrev_r <= '0;
    end else begin
      binMeta_r <= binSignals;
      binSync_r <= binMeta_r;
      binPrev_r <= binSync_r;
    end
  end

  //===========================================================================
  // settings registers
  logic              disable_r, mode_r, auto_r;
  logic [1:0]        rate_r;
  logic [31:0]       clrIdx_r;
  logic [17:0]       recLen_r;
  logic [8:0]        pre_r;
  logic [TRIG_W-1:0] trigSel_r;
  logic [4:0]        anaSel_r [`DRC_NUM_ANA];
  logic [6:0]        digSel_r [`DRC_NUM_DIG];
  logic [6:0]        count_r;
  logic [2:0]        xferCnt_r;
  drc_state_t        state_r, state_nxt;

  // AXI write path: take address and data in either order
  logic        awHave_r, wHave_r;
  logic [11:0] awAddr_r;
  logic [31:0] wData_r;
  wire         doWrite = awHave_r && wHave_r && !s_axi_bvalid;
  wire  [11:0] wa      = awAddr_r;
  assign s_axi_awready = !awHave_r;
  assign s_axi_wready  = !wHave_r;
  assign s_axi_bresp   = 2'h0;
  wire wrCtrl  = doWrite && wa == `DRC_OFS_CTRL;
  wire wrClr   = doWrite && wa == `DRC_OFS_CLRIDX;
  wire wrCmd   = doWrite && wa == `DRC_OFS_CMD;
  wire wrLen   = doWrite && wa == `DRC_OFS_RECLEN;
  wire wrPre   = doWrite && wa == `DRC_OFS_PRETRIG;
  wire wrTrig  = doWrite && wa == `DRC_OFS_TRIGSEL;
  wire wrXfer  = doWrite && wa == `DRC_OFS_XFER;
  // one-shot command bits self-clear: nothing is stored [RL6] [RL7]
  wire manTrig = wrCmd && wData_r[`DRC_CMD_TRIG];
  wire clrAll  = wrCmd && wData_r[`DRC_CMD_CLRALL];
  wire clrNew  = wrCmd && wData_r[`DRC_CMD_CLRNEW];
  wire clrOld  = wrCmd && wData_r[`DRC_CMD_CLROLD];
  wire clrSel  = wrClr && wData_r != 32'h0 && wData_r <= {25'h0, count_r}; // [RL5]

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
      awAddr_r <= 12'h000;
      wData_r  <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
      end
      if (doWrite) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // out-of-range length and pre-trigger writes are clamped into range
  wire [17:0] lenIn = wData_r[17:0] < `DRC_RECLEN_MIN ? `DRC_RECLEN_MIN :
                      wData_r[17:0] > `DRC_RECLEN_MAX ? `DRC_RECLEN_MAX :
                      wData_r[17:0];
  wire [8:0]  preIn = wData_r[8:0] < `DRC_PRE_MIN ? `DRC_PRE_MIN :
                      wData_r[8:0] > `DRC_PRE_MAX ? `DRC_PRE_MAX :
                      wData_r[8:0];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      disable_r <= 1'b0; // [RL3]
      mode_r    <= 1'b0; // [RL14]
      rate_r    <= 2'h0; // [RL15]
      auto_r    <= 1'b0;
      clrIdx_r  <= 32'h0;
      recLen_r  <= `DRC_RECLEN_RST; // [RL13]
      pre_r     <= `DRC_PRE_RST; // [RL17]
      trigSel_r <= '0;
    end else begin
      if (wrCtrl) begin
        disable_r <= wData_r[`DRC_CTRL_DIS];
        mode_r    <= wData_r[`DRC_CTRL_MODE];
        rate_r    <= wData_r[`DRC_CTRL_RATE+:2];
        auto_r    <= wData_r[`DRC_CTRL_AUTO];
      end
      if (wrClr) clrIdx_r <= wData_r;
      if (wrLen) recLen_r <= lenIn; // [RL13]
      if (wrPre) pre_r <= preIn; // [RL17]
      if (wrTrig) trigSel_r <= wData_r[TRIG_W-1:0]; // [RL12]
    end
  end

  // digital slot map is written via an indirect port: DIGSEL = slot<<8|sig
  wire wrDig = doWrite && wa == `DRC_OFS_DIGSEL;
  logic [6:0] digSlotIdx, digSigIdx;
  assign digSlotIdx = wData_r[14:8];
  assign digSigIdx  = wData_r[6:0];
  // slot maps: one generate per slot
  genvar g;
  generate
    for (g = 0; g < `DRC_NUM_ANA; g++) begin : gAna
      wire wrA = doWrite && wa == 12'(`DRC_OFS_ANASEL + 4 * g);
      always_ff @(posedge clock or posedge reset) begin
        if (reset) anaSel_r[g] <= 5'h0;
        else if (wrA) anaSel_r[g] <= wData_r[4:0]; // [RL18]
      end
      // code 0 leaves the slot unused, n selects channel n-1
      wire [4:0] ch = anaSel_r[g] - 5'h1;
      always_ff @(posedge clock or posedge reset) begin
        if (reset) anaSlotData[g] <= '0;
        else if (anaStrobe)
          anaSlotData[g] <= anaSel_r[g] == 5'h0 ? '0 :
            anaSamples[int'(ch)*SAMP_W +: SAMP_W]; // [RL18]
      end
    end
    for (g = 0; g < `DRC_NUM_DIG; g++) begin : gDig
      wire wrD = wrDig && digSlotIdx == 7'(g);
      always_ff @(posedge clock or posedge reset) begin
        if (reset) digSel_r[g] <= 7'(g % TRIG_W);
        else if (wrD) digSel_r[g] <= digSigIdx; // [RL19]
      end
    end
  endgenerate

  //===========================================================================
  // 5 ms digital sampling tick
  logic [31:0] digCnt_r;
  wire digTick = digCnt_r == 32'(DIG_CYC - 1);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) digCnt_r <= 32'h0;
    else digCnt_r <= digTick ? 32'h0 : digCnt_r + 32'h1; // [RL16]
  end
  logic [`DRC_NUM_DIG-1:0] digNow;
  always_comb begin
    digNow = '0;
    for (int i = 0; i < `DRC_NUM_DIG; i++)
      digNow[i] = binSync_r[int'(digSel_r[i]) % TRIG_W]; // [RL19]
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      digSlotData  <= '0;
      digSlotValid <= 1'b0;
    end else begin
      digSlotValid <= digTick; // [RL16]
      if (digTick) digSlotData <= digNow; // [RL16]
    end
  end

  //===========================================================================
  // capacity figures (simplified: sample reserve over per-second rate)
  logic [4:0]  anaUsed;
  always_comb begin
    anaUsed = 5'h0;
    for (int i = 0; i < `DRC_NUM_ANA; i++)
      anaUsed = anaUsed + 5'(anaSel_r[i] != 5'h0);
  end
  wire [31:0] perSec = 32'(50 * (int'(anaUsed) + 1) * (64 >> rate_r))
                       + 32'(200 * `DRC_NUM_DIG);
  wire        noTrig = trigSel_r == '0;
  // zero length without a trigger input blocks ready [RL22]
  wire [31:0] maxLenMs = noTrig ? 32'h0 :
                 32'((64'(`DRC_SAMPLE_BYTES) * 64'd1000) / 64'(perSec)); // [RL9]
  wire [31:0] lenMs = 32'(recLen_r) * 32'd10;
  wire [31:0] fitRaw = lenMs == 32'h0 ? 32'h0 : maxLenMs / lenMs;
  wire [6:0]  maxNum = fitRaw > 32'(`DRC_MAX_REC) ? `DRC_MAX_REC
                       : fitRaw[6:0]; // [RL8] [RL2]
  wire [31:0] maxPreMs = maxLenMs < lenMs ? maxLenMs : lenMs; // [RL10]
  wire        cfgBad = maxLenMs == 32'h0 || maxNum == 7'h0; // [RL22]

  //===========================================================================
  // capture state machine
  logic [31:0] msCnt_r, capMs_r, storeCnt_r;
  wire msTick = msCnt_r == 32'(MS_CYC - 1);
  wire full   = count_r >= maxNum;
  wire trigHit = |(binSync_r & ~binPrev_r & trigSel_r); // [RL1]
  // triggers only act from ready or full-with-overwrite [RL24]
  wire armed  = !disable_r && (state_r == DRC_READY ||
                (state_r == DRC_FULL && !mode_r));
  wire fire   = armed && (trigHit || manTrig); // [RL1] [RL24]
  wire capDone = msTick && capMs_r + 32'h1 >= lenMs;
  wire stDone  = storeCnt_r == 32'(STORE_CYC - 1);
  logic [6:0] xferWait_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DRC_READY, DRC_FULL: begin
        if (cfgBad) state_nxt = DRC_BADCFG;
        else if (fire) state_nxt = DRC_TRIGD;
        else state_nxt = full ? DRC_FULL : DRC_READY; // [RL14]
      end
      DRC_TRIGD:   if (capDone) state_nxt = DRC_CAPSTOR;
      DRC_CAPSTOR: state_nxt = DRC_STORING;
      DRC_STORING: if (stDone) state_nxt = full && mode_r ? DRC_FULL
                                            : DRC_READY;
      DRC_BADCFG:  if (!cfgBad) state_nxt = DRC_READY; // [RL22]
      default:     state_nxt = DRC_BADCFG;
    endcase
  end

  wire storeEnd = state_r == DRC_STORING && stDone;
  // full + overwrite drops the oldest, so the count holds [RL14]
  wire addRec  = storeEnd && (!full || !mode_r) && !(auto_r);
  wire delOne  = clrNew || clrOld || clrSel; // [RL5] [RL7]
  wire xferFree = xferCnt_r < `DRC_XFER_SLOTS;
  // one push at a time lets the slot count settle before the next [RL20]
  wire pushNow = xferWait_r != 7'h0 && xferFree && !recPush;
  wire [6:0] xferWait_nxt = xferWait_r + 7'(storeEnd && auto_r)
                            - 7'(pushNow);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r    <= DRC_READY;
      msCnt_r    <= 32'h0;
      capMs_r    <= 32'h0;
      storeCnt_r <= 32'h0;
      count_r    <= 7'h0;
      xferCnt_r  <= 3'h0;
      xferWait_r <= 7'h0;
      recPush    <= 1'b0;
    end else begin
      state_r    <= state_nxt; // [RL4]
      msCnt_r    <= msTick ? 32'h0 : msCnt_r + 32'h1;
      if (state_r != DRC_TRIGD) capMs_r <= 32'h0;
      else if (msTick) capMs_r <= capMs_r + 32'h1;
      storeCnt_r <= state_r == DRC_STORING ? storeCnt_r + 32'h1 : 32'h0;
      // transferred recordings leave the normal store [RL20] [RL21]
      recPush <= pushNow;
      xferWait_r <= xferWait_nxt; // [RL20]
      if (clrAll) count_r <= 7'h0; // [RL7]
      else if (addRec && !(full && !mode_r)) count_r <= count_r + 7'h1;
      else if (storeEnd && !auto_r && full && !mode_r) count_r <= count_r;
      else if (delOne && count_r != 7'h0) count_r <= count_r - 7'h1;
      if (recPush && !(xferTaken && xferCnt_r != 3'h0))
        xferCnt_r <= xferCnt_r + 3'h1; // [RL20]
      else if (!recPush && xferTaken && xferCnt_r != 3'h0)
        xferCnt_r <= xferCnt_r - 3'h1;
    end
  end
  // pre-trigger ring: samples flow while armed [RL23]
  assign preWindow    = armed && state_r != DRC_BADCFG;
  assign anaSlotValid = anaStrobe && (preWindow || state_r == DRC_TRIGD);

  //===========================================================================
  // AXI read path
  logic [31:0] rd;
  wire  [11:0] ra = s_axi_araddr;
  always_comb begin
    case (ra)
      `DRC_OFS_CTRL:    rd = {27'h0, auto_r, rate_r, mode_r, disable_r};
      `DRC_OFS_STATUS:  rd = {29'h0, state_r}; // [RL4]
      `DRC_OFS_CLRIDX:  rd = clrIdx_r;
      `DRC_OFS_CMD:     rd = 32'h0; // [RL6]
      `DRC_OFS_RECLEN:  rd = {14'h0, recLen_r};
      `DRC_OFS_PRETRIG: rd = {23'h0, pre_r};
      `DRC_OFS_TRIGSEL: rd = 32'(trigSel_r);
      `DRC_OFS_MAXNUM:  rd = {25'h0, maxNum}; // [RL8]
      `DRC_OFS_MAXLEN:  rd = maxLenMs; // [RL9]
      `DRC_OFS_MAXPRE:  rd = maxPreMs; // [RL10]
      `DRC_OFS_COUNT:   rd = {25'h0, count_r}; // [RL11]
      `DRC_OFS_XFER:    rd = {29'h0, xferCnt_r};
      default:          rd = 32'h0;
    endcase
  end
  wire rdMapped = ra <= `DRC_OFS_DIGSEL;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd;
      s_axi_rresp  <= rdMapped ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verification/disturbance_recorder_control_test.sv
// self-checking bench for the recorder control
`timescale 1ns/1ps
`default_nettype none
`include "drc_map.svh"
module disturbance_recorder_control_test;
  import drc_pkg::*;
  logic clock = 0, reset = 1, fireReq = 0, takeReq = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, anaStrobe, xferTaken;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, anaSlotValid, digSlotValid, preWindow, recPush;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] binSignals;
  logic [511:0] anaSamples;
  logic [15:0] anaSlotData [`DRC_NUM_ANA];
  logic [`DRC_NUM_DIG-1:0] digSlotData;
  logic [65:0] q[$], qe;
  int failures = 0, compares = 0, cyc = 0, pushes = 0;
  logic anaChk = 0, anaPend = 0;
  logic [15:0] anaExp;
  always #10 clock = ~clock;
  drc_recorder_ctrl #(.DIG_CYC(10), .MS_CYC(4), .STORE_CYC(4)) DUT (
    .clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .binSignals, .anaSamples, .anaStrobe, .anaSlotData, .anaSlotValid,
    .digSlotData, .digSlotValid, .preWindow, .recPush, .xferTaken);
  drc_relay_model relay (.clock, .reset, .fireReq, .takeReq, .binSignals,
    .anaSamples, .anaStrobe, .xferTaken);
  //==========================================================
  // checking and closing
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (recPush === 1'b1) pushes++;
    if (anaPend) chk(34'(anaSlotData[0]), 34'(anaExp));
    if (anaPend) chk(34'(anaSlotData[1]), 34'h0);
    anaPend = anaChk && anaStrobe === 1'b1;
    anaExp = anaSamples[15:0];
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      qe = q.pop_front();
      if (qe[65:34] != 0) chk({s_axi_rresp, s_axi_rdata & qe[65:34]}, qe[33:0]);
    end
    if (cyc == 90000) begin
      failures++;
      test_done();
    end
  end
  //==========================================================
  // bus master
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [33:0] x);
    q.push_back({m, x});
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ex(input logic [11:0] a, input logic [31:0] d);
    rd(a, 32'hffffffff, {2'h0, d});
  endtask
  task automatic pulse(input logic trig);
    @(posedge clock);
    if (trig) fireReq <= 1'b1; else takeReq <= 1'b1;
    @(posedge clock);
    fireReq <= 1'b0;
    takeReq <= 1'b0;
  endtask
  // lets the capture start, then polls until the state is ready again
  task automatic wait_idle;
    repeat (30) @(posedge clock);
    for (int i = 0; i < 1500; i++) begin
      rd(`DRC_OFS_STATUS, 32'h0, 34'h0);
      if (rdv[2:0] == 3'h0) break;
    end
    chk(34'(rdv[2:0]), 34'h0);
  endtask
  //==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hb72bab6b));
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    ex(`DRC_OFS_CTRL, 32'h0);
    ex(`DRC_OFS_RECLEN, 32'h64);
    ex(`DRC_OFS_PRETRIG, 32'h2);
    ex(`DRC_OFS_COUNT, 32'h0);
    ex(`DRC_OFS_STATUS, {29'h0, DRC_BADCFG});
    ex(`DRC_OFS_MAXLEN, 32'h0);
    wr(`DRC_OFS_RECLEN, 32'h3ffff);
    ex(`DRC_OFS_RECLEN, 32'h2bf20);
    wr(`DRC_OFS_RECLEN, 32'h0);
    ex(`DRC_OFS_RECLEN, 32'ha);
    wr(`DRC_OFS_PRETRIG, 32'h1ff);
    ex(`DRC_OFS_PRETRIG, 32'h12c);
    wr(`DRC_OFS_PRETRIG, 32'h0);
    ex(`DRC_OFS_PRETRIG, 32'h2);
    rd(12'h100, 32'hffffffff, {2'h2, 32'h0});
    for (int r = 3; r >= 0; r--) begin
      wr(`DRC_OFS_CTRL, 32'(r << 2) | 32'h2);
      ex(`DRC_OFS_CTRL, 32'(r << 2) | 32'h2);
    end
    wr(`DRC_OFS_CTRL, 32'h0);
    wr(`DRC_OFS_RECLEN, 32'h32);
    wr(`DRC_OFS_TRIGSEL, 32'h1);
    ex(`DRC_OFS_STATUS, {29'h0, DRC_READY});
    rd(`DRC_OFS_MAXLEN, 32'h0, 34'h0);
    chk(34'(rdv != 0), 34'h1);
    ex(`DRC_OFS_MAXNUM, 32'h64);
    ex(`DRC_OFS_MAXPRE, 32'h1f4);
    wr(`DRC_OFS_CMD, 32'h1);
    ex(`DRC_OFS_CMD, 32'h0);
    wait_idle();
    ex(`DRC_OFS_COUNT, 32'h1);
    pulse(1'b1);
    repeat (100) @(posedge clock);
    pulse(1'b1);
    wait_idle();
    ex(`DRC_OFS_COUNT, 32'h2);
    wr(`DRC_OFS_CTRL, 32'h1);
    pulse(1'b1);
    wr(`DRC_OFS_CMD, 32'h1);
    repeat (200) @(posedge clock);
    ex(`DRC_OFS_COUNT, 32'h2);
    wr(`DRC_OFS_CTRL, 32'h0);
    wr(`DRC_OFS_CMD, 32'h1);
    wait_idle();
    wr(`DRC_OFS_CLRIDX, 32'h0);
    ex(`DRC_OFS_COUNT, 32'h3);
    wr(`DRC_OFS_CLRIDX, 32'h1);
    ex(`DRC_OFS_COUNT, 32'h2);
    wr(`DRC_OFS_CMD, 32'h4);
    ex(`DRC_OFS_COUNT, 32'h1);
    wr(`DRC_OFS_CMD, 32'h8);
    ex(`DRC_OFS_COUNT, 32'h0);
    wr(`DRC_OFS_CMD, 32'h1);
    wait_idle();
    wr(`DRC_OFS_CMD, 32'h2);
    ex(`DRC_OFS_COUNT, 32'h0);
    wr(`DRC_OFS_CTRL, 32'h10);
    repeat (7) begin
      wr(`DRC_OFS_CMD, 32'h1);
      wait_idle();
    end
    repeat (20) @(posedge clock);
    ex(`DRC_OFS_COUNT, 32'h0);
    chk(34'(pushes), 34'h6);
    ex(`DRC_OFS_XFER, 32'h6);
    pulse(1'b0);
    repeat (60) @(posedge clock);
    chk(34'(pushes), 34'h7);
    wr(`DRC_OFS_ANASEL, 32'h1);
    anaChk <= 1'b1;
    repeat (20) @(posedge clock);
    test_done();
  end
endmodule
`default_nettype wire

//--- verification/drc_monitor.sv
// port assertions for the recorder control
`timescale 1ns/1ps
`default_nettype none
module drc_monitor #(
  parameter int DIG_CYC = 10
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        anaStrobe,
  input wire logic        anaSlotValid,
  input wire logic        digSlotValid,
  input wire logic        preWindow,
  input wire logic        recPush
);
  //===========================================================
  // digital tick spacing
  logic [31:0] gap_r;
  logic        seen_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gap_r  <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= digSlotValid ? 32'h1 : gap_r + 32'h1;
      seen_r <= seen_r | digSlotValid;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  //===========================================================
  // checks
  a_dig_period: assert property (digSlotValid && seen_r |-> gap_r == DIG_CYC)
    else $error("digital tick period wrong");
  a_dig_gap: assert property (digSlotValid |=> !digSlotValid [*8])
    else $error("digital tick too soon");
  a_ana_armed: assert property (preWindow && anaStrobe |-> anaSlotValid)
    else $error("armed sample not passed");
  a_ana_cause: assert property (anaSlotValid |-> anaStrobe)
    else $error("slot sample without strobe");
  a_push_pulse: assert property (recPush |=> !recPush)
    else $error("push longer than one cycle");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data unstable");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
endmodule
bind drc_recorder_ctrl drc_monitor #(.DIG_CYC(DIG_CYC)) mon (.clock, .reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .anaStrobe, .anaSlotValid, .digSlotValid, .preWindow, .recPush);
`default_nettype wire

//--- verification/drc_relay_model.sv
// relay side: samples, binary signals and transfer client
`timescale 1ns/1ps
`default_nettype none
module drc_relay_model #(
  parameter int TRIG_W = 32,
  parameter int AW     = 512
) (
  input wire logic     clock,
  input wire logic     reset,
  input wire logic     fireReq,
  input wire logic     takeReq,
  output logic [TRIG_W-1:0] binSignals,
  output logic [AW-1:0]     anaSamples,
  output logic              anaStrobe,
  output logic              xferTaken
);
  logic [1:0] ph_r;
  logic [2:0] hold_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ph_r <= 2'h0;
      hold_r <= 3'h0;
      binSignals <= '0;
      anaSamples <= '0;
      anaStrobe <= 1'b0;
      xferTaken <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      anaStrobe <= (ph_r == 2'h3);
      anaSamples <= {anaSamples[AW-33:0], $urandom()};
      // held long enough to cross the two-stage synchroniser
      hold_r <= fireReq ? 3'h5 : (hold_r != 3'h0 ? hold_r - 3'h1 : 3'h0);
      binSignals[0] <= (hold_r != 3'h0);
      // unselected inputs toggle freely and must not trigger
      binSignals[TRIG_W-1:1] <= (TRIG_W-1)'($urandom());
      xferTaken <= takeReq;
    end
  end
endmodule
`default_nettype wire
